// ==== verilog/primary_bus_hold_control.sv ====
`timescale 1ns/1ps
//Contract
// - 32-bit two-way data bus with keepers
// - Read_not_write high on reads, low writes
// - Strobe asserted for every external access
// - Four decoded page strobes from address
// - Access completes only after ready seen
// - Finish ongoing access before releasing bus
// - Float bus, suspend traffic while held
// - Drive acknowledge low answering hold request
// - Acknowledge high on hold high or ignore
// - Stay in reset while reset low (code: with shutdown also low it goes to S_LOST, core_in_reset low)
// - After reset fetch from vector location
// - Edge select makes interrupts edge detected
// - Acknowledge pulse only on acknowledge instruction
// - Shutdown low floats every pin
// - Shutdown corrupts state; reset restores it
// - Per-pin float set: shutdown, hold, reset
module primary_bus_hold_control (
	input wire logic clock,
	input wire logic rst,
	// Pins from the outside world
	input wire logic reset_in_n,
	input wire logic hold_request_n,
	input wire logic ready,
	input wire logic shutdown_tristate_n,
	input wire logic edge_detect_select,
	input wire logic [bus_hold_pkg::IRQ_N-1:0] external_irq_n,
	input wire logic boot_mode_select,
	input wire logic [bus_hold_pkg::DATA_W-1:0] data_in,
	// Core side
	input wire logic hold_ignore_bit,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [bus_hold_pkg::ADDR_W-1:0] req_addr,
	input wire logic [bus_hold_pkg::DATA_W-1:0] req_wdata,
	input wire logic int_ack_strobe_exec,
	input wire logic [bus_hold_pkg::IRQ_N-1:0] irq_clear,
	output logic req_ready,
	output logic resp_valid,
	output logic [bus_hold_pkg::DATA_W-1:0] resp_rdata,
	output logic vector_valid,
	output logic [bus_hold_pkg::DATA_W-1:0] vector_addr,
	output logic core_in_reset,
	output logic state_lost,
	output logic [bus_hold_pkg::IRQ_N-1:0] irq_request,
	output logic boot_mode,
	// Pins to the outside world
	output logic [bus_hold_pkg::ADDR_W-1:0] address_lines,
	output logic address_oe,
	output logic [bus_hold_pkg::DATA_W-1:0] data_out,
	output logic data_oe,
	output logic [bus_hold_pkg::DATA_W-1:0] data_keeper,
	output logic read_not_write,
	output logic read_not_write_oe,
	output logic external_access_strobe_n,
	output logic strobe_oe,
	output logic [bus_hold_pkg::PAGE_N-1:0] page_select_strobes_n,
	output logic page_oe,
	output logic bus_release_ack_n,
	output logic release_ack_oe,
	output logic int_ack_strobe_n,
	output logic int_ack_oe
);
	import bus_hold_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	localparam int SYNC_W = DATA_W + IRQ_N + 6;
	// Idle levels: hold and shutdown high, ready low, so no false request
	localparam logic [SYNC_W-1:0] SYNC_INIT = {{DATA_W{1'b0}},
		{IRQ_N{1'b1}}, 6'h18};
	logic [SYNC_W-1:0] sync_out;
	logic [DATA_W-1:0] data_s;
	logic [IRQ_N-1:0] irq_s;
	logic reset_s, hold_s, ready_s, shz_s, edge_s, boot_s;

	// Ready and data share latency, so read data lines up with ready
	pin_sync #(.WIDTH(SYNC_W), .INIT(SYNC_INIT)) u_sync (
		.clock(clock),
		.rst(rst),
		.din({data_in, external_irq_n, reset_in_n, hold_request_n,
			shutdown_tristate_n, ready, edge_detect_select,
			boot_mode_select}),
		.dout(sync_out)
	);
	assign {data_s, irq_s, reset_s, hold_s, shz_s, ready_s, edge_s,
		boot_s} = sync_out;

	// ------------------------------------------------------------
	// Bus sequencer
	// ------------------------------------------------------------
	bus_state_t state, next_state;
	logic [2:0] wait_cnt, next_wait_cnt;
	logic vec_pending, next_vec_pending;
	logic next_req_ready, next_resp_valid, next_vector_valid;
	logic [DATA_W-1:0] next_resp_rdata, next_vector_addr;
	logic next_core_in_reset, next_state_lost, next_boot_mode;
	logic [ADDR_W-1:0] next_address_lines;
	logic [DATA_W-1:0] next_data_out, next_data_keeper;
	logic next_read_not_write, next_strobe_n;
	logic [PAGE_N-1:0] next_page_n;
	logic next_ack_n, next_int_ack_strobe_n;
	logic next_addr_oe, next_data_oe, next_strobe_oe, next_io_oe;
	logic shz_on, hold_wanted, in_hold, in_reset;

	// Next state and pin values of the bus sequencer
	always_comb begin
		shz_on = !shz_s;
		hold_wanted = !hold_s && !hold_ignore_bit;
		next_state = state;
		next_wait_cnt = wait_cnt;
		next_vec_pending = vec_pending;
		next_resp_valid = 1'b0;
		next_vector_valid = 1'b0;
		next_resp_rdata = resp_rdata;
		next_vector_addr = vector_addr;
		next_state_lost = state_lost;
		next_address_lines = address_lines;
		next_data_out = data_out;
		next_read_not_write = read_not_write;
		next_boot_mode = boot_mode;
		case (state)
			S_RESET: begin
				next_boot_mode = boot_s;
				next_vec_pending = 1'b1;
				if (reset_s)
					next_state = S_IDLE;
			end
			S_IDLE: begin
				next_wait_cnt = 3'h0;
				if (vec_pending) begin
					next_state = S_ACCESS;
					next_address_lines = RESET_VECTOR_ADDR;
					next_read_not_write = 1'b1;
				end else if (req_valid && req_ready) begin
					next_state = S_ACCESS;
					next_address_lines = req_addr;
					next_read_not_write = !req_write;
					next_data_out = req_wdata;
				end else if (hold_wanted) begin
					next_state = S_HOLD;
				end
			end
			S_ACCESS: begin
				if (wait_cnt != ACCESS_MIN_CYCLES)
					next_wait_cnt = wait_cnt + 3'h1;
				else if (ready_s) begin
					next_state = S_IDLE;
					if (vec_pending) begin
						next_vec_pending = 1'b0;
						next_vector_valid = 1'b1;
						next_vector_addr = data_s;
					end else begin
						next_resp_valid = 1'b1;
						next_resp_rdata = data_s;
					end
				end
			end
			S_HOLD: begin
				// release on hold high or ignore bit
				if (!hold_wanted)
					next_state = S_IDLE;
			end
			S_LOST: begin
				next_state = S_LOST;
			end
			default: begin
				next_state = S_RESET;
			end
		endcase
		// shutdown spoils state until reset with it off
		if (shz_on) begin
			next_state = S_LOST;
			next_state_lost = 1'b1;
		end else if (!reset_s) begin
			// held in reset while the pin is low
			next_state = S_RESET;
			next_state_lost = 1'b0;
		end
		in_hold = next_state == S_HOLD;
		in_reset = next_state == S_RESET;
		next_core_in_reset = in_reset;
		next_req_ready = next_state == S_IDLE && !next_vec_pending &&
			!in_hold;
		next_strobe_n = next_state != S_ACCESS;
		// one page strobe per address page
		next_page_n = next_strobe_n ? PAGES_IDLE :
			~(PAGE_ONE << next_address_lines[PAGE_HI:PAGE_LO]);
		next_ack_n = !in_hold;
		// one low cycle per acknowledge instruction
		next_int_ack_strobe_n = !int_ack_strobe_exec;
		next_addr_oe = !shz_on && !in_hold && !in_reset;
		next_strobe_oe = !shz_on && !in_hold;
		next_io_oe = !shz_on;
		// data floats in hold; driven only for writes
		next_data_oe = !shz_on && !in_hold &&
			next_state == S_ACCESS && !next_read_not_write;
		// keeper follows the last level on the lines
		next_data_keeper = next_data_oe ? next_data_out : data_s;
	end

	// Bus sequencer registers; every pin comes from here
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= S_RESET;
			wait_cnt <= 3'h0;
			vec_pending <= 1'b1;
			req_ready <= 1'b0;
			resp_valid <= 1'b0;
			resp_rdata <= DATA_RESET;
			vector_valid <= 1'b0;
			vector_addr <= DATA_RESET;
			core_in_reset <= 1'b1;
			state_lost <= 1'b0;
			boot_mode <= 1'b0;
			address_lines <= ADDR_RESET;
			address_oe <= 1'b0;
			data_out <= DATA_RESET;
			data_oe <= 1'b0;
			data_keeper <= DATA_RESET;
			read_not_write <= 1'b1;
			read_not_write_oe <= 1'b0;
			external_access_strobe_n <= 1'b1;
			strobe_oe <= 1'b0;
			page_select_strobes_n <= PAGES_IDLE;
			page_oe <= 1'b0;
			bus_release_ack_n <= 1'b1;
			release_ack_oe <= 1'b0;
			int_ack_strobe_n <= 1'b1;
			int_ack_oe <= 1'b0;
		end else begin
			state <= next_state;
			wait_cnt <= next_wait_cnt;
			vec_pending <= next_vec_pending;
			req_ready <= next_req_ready;
			resp_valid <= next_resp_valid;
			resp_rdata <= next_resp_rdata;
			vector_valid <= next_vector_valid;
			vector_addr <= next_vector_addr;
			core_in_reset <= next_core_in_reset;
			state_lost <= next_state_lost;
			boot_mode <= next_boot_mode;
			address_lines <= next_address_lines;
			address_oe <= next_addr_oe;
			data_out <= next_data_out;
			data_oe <= next_data_oe;
			data_keeper <= next_data_keeper;
			read_not_write <= next_read_not_write;
			read_not_write_oe <= next_addr_oe;
			external_access_strobe_n <= next_strobe_n;
			strobe_oe <= next_strobe_oe;
			page_select_strobes_n <= next_page_n;
			page_oe <= next_addr_oe;
			bus_release_ack_n <= next_ack_n;
			release_ack_oe <= next_io_oe;
			int_ack_strobe_n <= next_int_ack_strobe_n;
			int_ack_oe <= next_io_oe;
		end
	end

	// ------------------------------------------------------------
	// Interrupt detection
	// ------------------------------------------------------------
	logic [IRQ_N-1:0] irq_prev, next_irq_prev, next_irq_request, irq_fall;

	// Edge flags are sticky; a new edge beats a clear in the same cycle
	always_comb begin
		next_irq_prev = irq_s;
		irq_fall = irq_prev & ~irq_s;
		for (int i = 0; i < IRQ_N; i++) begin
			if (edge_s)
				next_irq_request[i] = irq_fall[i] ||
					(irq_request[i] && !irq_clear[i]);
			else
				next_irq_request[i] = !irq_s[i];
		end
	end

	// Interrupt registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_prev <= {IRQ_N{1'b1}};
			irq_request <= {IRQ_N{1'b0}};
		end else begin
			irq_prev <= next_irq_prev;
			irq_request <= next_irq_request;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	write_dir_a: assert property (@(posedge clock) disable iff (rst)
		data_oe |-> !read_not_write && !external_access_strobe_n)
		else $error("data driven outside a write access");
	access_strobe_a: assert property (@(posedge clock) disable iff (rst)
		resp_valid || vector_valid |-> $past(!external_access_strobe_n, 1)
			&& external_access_strobe_n)
		else $error("access finished without strobe");
	page_decode_a: assert property (@(posedge clock) disable iff (rst)
		!external_access_strobe_n |-> page_select_strobes_n ==
			~(PAGE_ONE << address_lines[PAGE_HI:PAGE_LO]))
		else $error("page strobe does not match address");
	ready_wait_a: assert property (@(posedge clock) disable iff (rst)
		$rose(external_access_strobe_n) && !core_in_reset &&
			!state_lost |-> $past(ready_s, 1))
		else $error("access ended without ready");
	hold_quiet_a: assert property (@(posedge clock) disable iff (rst)
		!bus_release_ack_n |-> !address_oe && !data_oe && !strobe_oe &&
			!read_not_write_oe && external_access_strobe_n)
		else $error("bus driven while held");
	ack_cause_a: assert property (@(posedge clock) disable iff (rst)
		$fell(bus_release_ack_n) |-> $past(!hold_s && !hold_ignore_bit, 1))
		else $error("acknowledge without hold request");
	ack_release_a: assert property (@(posedge clock) disable iff (rst)
		!bus_release_ack_n && (hold_s || hold_ignore_bit) |=>
			bus_release_ack_n)
		else $error("acknowledge not released");
	reset_hold_a: assert property (@(posedge clock) disable iff (rst)
		!reset_s && shz_s |=> core_in_reset && !address_oe && !page_oe)
		else $error("not in reset while reset pin low");
	int_ack_strobe_pulse_a: assert property (@(posedge clock) disable iff (rst)
		$fell(int_ack_strobe_n) |-> $past(int_ack_strobe_exec, 1) ##1
			(int_ack_strobe_n == !$past(int_ack_strobe_exec, 1)))
		else $error("acknowledge pulse without instruction");
	shutdown_float_a: assert property (@(posedge clock) disable iff (rst)
		!shz_s |=> !address_oe && !data_oe && !strobe_oe && !page_oe &&
			!release_ack_oe && !int_ack_oe && state_lost)
		else $error("pin driven during shutdown");
endmodule // primary_bus_hold_control

// ==== include/bus_hold_pkg.sv ====
package bus_hold_pkg;
	// ------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int ADDR_W = 24;
	localparam int IRQ_N = 4;
	localparam int PAGE_N = 4;
	// Page number sits in the top address bits
	localparam int PAGE_HI = 23;
	localparam int PAGE_LO = 22;

	// ------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------
	// Location read after reset release to find the start address
	localparam logic [23:0] RESET_VECTOR_ADDR = 24'h000000;
	// Counts run with the strobe low before ready is sampled, so at least 4 strobe-low cycles; covers the ready synchroniser
	localparam logic [2:0] ACCESS_MIN_CYCLES = 3'h3;
	localparam logic [3:0] PAGES_IDLE = 4'hF;
	localparam logic [3:0] PAGE_ONE = 4'h1;
	localparam logic [31:0] DATA_RESET = 32'h00000000;
	localparam logic [23:0] ADDR_RESET = 24'h000000;

	typedef enum logic [2:0] {
		S_RESET,
		S_IDLE,
		S_ACCESS,
		S_HOLD,
		S_LOST
	} bus_state_t;
endpackage

// ==== verilog/pin_sync.sv ====
`timescale 1ns/1ps
// Two-flop synchroniser for pins arriving from outside the clock domain
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta;

	// First stage is read only by the second
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta <= INIT;
			dout <= INIT;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // pin_sync

// ==== bench/bus_partner.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Far-side memory with a programmable wait
// ------------------------------------------------------------
module bus_partner (
	input wire logic clock,
	input wire logic [23:0] address_lines,
	input wire logic [31:0] data_out,
	input wire logic data_oe,
	input wire logic read_not_write,
	input wire logic external_access_strobe_n,
	input wire logic strobe_oe,
	input wire logic [3:0] wait_cycles,
	output logic ready,
	output logic [31:0] data_in
);
	logic [31:0] mem [16];
	logic [3:0] waited;
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = 32'hA5000000 | 32'(i);
		end
		ready = 1'b0;
		data_in = 32'h00000000;
		waited = 4'h0;
	end
	// Acts just after the edge; outside an access data_in keeps its level,
	// as the keepers would
	always @(posedge clock) begin
		#2;
		if (!(strobe_oe && !external_access_strobe_n)) begin
			waited = 4'h0;
			ready = 1'b0;
		end else begin
			if (waited != 4'hF) begin
				waited = waited + 4'h1;
			end
			ready = (waited > wait_cycles);
			if (read_not_write) begin
				data_in = mem[address_lines[3:0]];
			end else if (data_oe) begin
				data_in = data_out;
				mem[address_lines[3:0]] = data_out;
			end
		end
	end
endmodule // bus_partner

// ==== bench/test_primary_bus_hold_control.sv ====
`timescale 1ns/1ps
module test_primary_bus_hold_control;
	import bus_hold_pkg::*;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	typedef struct packed {
		logic w;
		logic [23:0] a;
		logic [31:0] d;
	} row_t;
	logic clock = 1'b0, rst = 1'b1, reset_in_n = 1'b0, hold_request_n = 1'b1;
	logic ready, shutdown_tristate_n = 1'b1, edge_detect_select = 1'b0;
	logic [3:0] external_irq_n = 4'hF, irq_clear = 4'h0, wait_cycles = 4'h1;
	logic boot_mode_select = 1'b0, hold_ignore_bit = 1'b0, req_valid = 1'b0;
	logic req_write = 1'b0, int_ack_strobe_exec = 1'b0;
	logic [23:0] req_addr = 24'h000000, address_lines;
	logic [31:0] data_in, req_wdata = 32'h00000000, resp_rdata, vector_addr;
	logic [31:0] data_out, data_keeper, q;
	logic req_ready, resp_valid, vector_valid, core_in_reset, state_lost;
	logic [3:0] irq_request, page_select_strobes_n;
	logic boot_mode, address_oe, data_oe, read_not_write, read_not_write_oe;
	logic external_access_strobe_n, strobe_oe, page_oe, bus_release_ack_n;
	logic release_ack_oe, int_ack_strobe_n, int_ack_oe;
	int n_fail = 0, checked = 0, cycles = 0;
	row_t rows [8];

	primary_bus_hold_control dut (.*);
	bus_partner mem_side (.*);

	// Free-running clock
	always #10 clock = ~clock;

	// Hang guard; an acknowledged hold must never see the strobe driven.
	// Looked at on the falling edge, where the pins have settled
	always @(negedge clock) begin
		cycles++;
		if (bus_release_ack_n === 1'b0 && release_ack_oe === 1'b1 &&
			strobe_oe !== 1'b0) begin
			check(32'h1, 32'h0);
		end
		if (cycles == 20000) begin
			n_fail++;
			results();
		end
	end

	task automatic tick();
		@(posedge clock);
		#2;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Bounded wait for a level; the caller's check catches a timeout
	task automatic wait_for(ref logic s, input logic v, input int lim);
		while (s !== v && lim > 0) begin
			tick();
			lim--;
		end
	endtask

	task automatic results();
		$display("Counts: %0d compared, %0d failed", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// One core access; pins are looked at while the strobe is low
	task automatic access(input logic w, input logic [23:0] a,
		input logic [31:0] d);
		int n;
		wait_for(req_ready, 1'b1, 100);
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		tick();
		req_valid = 1'b0;
		tick();
		check(32'(external_access_strobe_n), 32'h0);
		check(32'(read_not_write), 32'(!w));
		check(32'(data_oe), 32'(w));
		check(32'(page_select_strobes_n), {28'h0, ~(4'h1 << a[23:22])});
		check(32'(address_lines), 32'(a));
		n = 0;
		while (resp_valid !== 1'b1 && n < 100) begin
			tick();
			n++;
		end
		check(32'(n >= int'(wait_cycles) + 2), 32'h1);
		check(32'(resp_valid), 32'h1);
		q = resp_rdata;
	endtask

	initial begin
		rows[0] = '{1'b1, 24'h000001, 32'h11111111};
		rows[1] = '{1'b1, 24'h400002, 32'h22222222};
		rows[2] = '{1'b1, 24'h800003, 32'h33333333};
		rows[3] = '{1'b1, 24'hC00004, 32'h44444444};
		rows[4] = '{1'b0, 24'h000001, 32'h11111111};
		rows[5] = '{1'b0, 24'h400002, 32'h22222222};
		rows[6] = '{1'b0, 24'h800003, 32'h33333333};
		rows[7] = '{1'b0, 24'hC00004, 32'h44444444};
		tick();
		check(32'(core_in_reset), 32'h1);
		check(32'({address_oe, data_oe, strobe_oe, page_oe}), 32'h0);
		tick();
		rst = 1'b0;
		repeat (6) tick();
		check(32'({req_ready, core_in_reset}), 32'h1);
		check(32'({address_oe, read_not_write_oe, page_oe}), 32'h0);
		check(32'({strobe_oe, external_access_strobe_n}), 32'h3);
		reset_in_n = 1'b1;
		wait_for(vector_valid, 1'b1, 60);
		check(32'(vector_valid), 32'h1);
		check(vector_addr, 32'hA5000000);
		for (int i = 0; i < 8; i++) begin
			wait_cycles = 4'(i);
			access(rows[i].w, rows[i].a, rows[i].d);
			check(data_keeper, rows[i].d);
			if (!rows[i].w) begin
				check(q, rows[i].d);
			end
		end
		// Hold arriving mid-access: the access must finish first
		wait_cycles = 4'h6;
		fork
			access(1'b0, 24'h400002, 32'h00000000);
			begin
				repeat (3) tick();
				hold_request_n = 1'b0;
			end
		join
		check(q, 32'h22222222);
		wait_for(bus_release_ack_n, 1'b0, 10);
		check(32'({bus_release_ack_n, release_ack_oe}), 32'h1);
		check(32'({address_oe, data_oe, strobe_oe, read_not_write_oe,
			page_oe}), 32'h0);
		repeat (8) tick();
		check(32'(req_ready), 32'h0);
		hold_ignore_bit = 1'b1;
		wait_for(bus_release_ack_n, 1'b1, 10);
		check(32'(bus_release_ack_n), 32'h1);
		wait_for(req_ready, 1'b1, 10);
		check(32'(req_ready), 32'h1);
		// Drop the ignore bit only once the pin is seen high again
		hold_request_n = 1'b1;
		repeat (4) tick();
		check(32'(bus_release_ack_n), 32'h1);
		hold_ignore_bit = 1'b0;
		hold_request_n = 1'b0;
		wait_for(bus_release_ack_n, 1'b0, 10);
		check(32'(bus_release_ack_n), 32'h0);
		hold_request_n = 1'b1;
		wait_for(bus_release_ack_n, 1'b1, 10);
		check(32'({bus_release_ack_n, strobe_oe}), 32'h3);
		// Acknowledge pulse lasts exactly one cycle
		int_ack_strobe_exec = 1'b1;
		tick();
		int_ack_strobe_exec = 1'b0;
		check(32'({int_ack_strobe_n, int_ack_oe}), 32'h1);
		tick();
		check(32'(int_ack_strobe_n), 32'h1);
		// Level mode, then a one-cycle pulse in edge mode
		external_irq_n = 4'hE;
		repeat (4) tick();
		check(32'(irq_request), 32'h1);
		external_irq_n = 4'hF;
		repeat (4) tick();
		check(32'(irq_request), 32'h0);
		// Switch mode only with the pins idle, so no level is latched
		edge_detect_select = 1'b1;
		repeat (4) tick();
		check(32'(irq_request), 32'h0);
		external_irq_n = 4'hB;
		tick();
		external_irq_n = 4'hF;
		repeat (4) tick();
		check(32'(irq_request), 32'h4);
		irq_clear = 4'h4;
		tick();
		irq_clear = 4'h0;
		tick();
		check(32'(irq_request), 32'h0);
		// Shutdown floats everything and sticks until a device reset
		shutdown_tristate_n = 1'b0;
		repeat (4) tick();
		check(32'({address_oe, data_oe, strobe_oe, read_not_write_oe, page_oe,
			release_ack_oe, int_ack_oe}), 32'h0);
		check(32'({state_lost, req_ready}), 32'h2);
		shutdown_tristate_n = 1'b1;
		repeat (4) tick();
		check(32'({state_lost, req_ready}), 32'h2);
		reset_in_n = 1'b0;
		boot_mode_select = 1'b1;
		repeat (4) tick();
		reset_in_n = 1'b1;
		wait_for(req_ready, 1'b1, 80);
		check(32'({state_lost, req_ready}), 32'h1);
		check(32'(boot_mode), 32'h1);
		access(1'b0, 24'h800003, 32'h00000000);
		check(q, 32'h33333333);
		results();
	end
endmodule // test_primary_bus_hold_control
